// [rtl/synth_cfg_pkg.sv]
// Shared constants for the synthesizer configuration port.
// Assumes one system clock; all pins arrive synchronous to it.
package synth_cfg_pkg;

   localparam int FB_W    = 9;
   localparam int OD_W    = 2;
   localparam int TS_W    = 2;
   localparam int FRAME_W = TS_W + OD_W + FB_W;

   // Serial frame layout, first bit shifted in ends up at the top
   localparam int FRM_FB_LSB = 0;
   localparam int FRM_OD_LSB = FB_W;
   localparam int FRM_TS_LSB = FB_W + OD_W;

   // Reset values of the held configuration
   localparam logic [FB_W-1:0] FB_RST = 9'h019;
   localparam logic [OD_W-1:0] OD_RST = 2'h0;
   localparam logic [TS_W-1:0] TS_RST = 2'h0;

   // Output divider ratio width and lookup
   localparam int RATIO_W = 5;
   localparam logic [RATIO_W-1:0] OD_RATIO_0 = 5'h02;
   localparam logic [RATIO_W-1:0] OD_RATIO_1 = 5'h04;
   localparam logic [RATIO_W-1:0] OD_RATIO_2 = 5'h08;
   localparam logic [RATIO_W-1:0] OD_RATIO_3 = 5'h10;

   // Test output source select codes
   localparam logic [TS_W-1:0] TS_LOW    = 2'h0;
   localparam logic [TS_W-1:0] TS_SDATA  = 2'h1;
   localparam logic [TS_W-1:0] TS_FBDIV  = 2'h2;
   localparam logic [TS_W-1:0] TS_OUTDIV = 2'h3;

   function automatic logic [RATIO_W-1:0] odRatio(input logic [OD_W-1:0] code);
      case (code)
         2'h0:    odRatio = OD_RATIO_0;
         2'h1:    odRatio = OD_RATIO_1;
         2'h2:    odRatio = OD_RATIO_2;
         default: odRatio = OD_RATIO_3;
      endcase
   endfunction : odRatio

endpackage : synth_cfg_pkg

// [rtl/ratio_divider.sv]
// Programmable divider of the system clock with near-even duty.
// Assumes ratio is held stable; a change takes effect at wrap.
`timescale 1ns/1ns
module ratio_divider
   import synth_cfg_pkg::*;
#(
   parameter int W = 9
)
(
   input  wire logic         clock,
   input  wire logic         nrst,
   input  wire logic         hold,
   input  wire logic [W-1:0] ratio,
   output logic              divOut
);

   typedef struct packed {
      logic [W-1:0] count;
      logic [W-1:0] ratioHeld;
      logic         out;
   } div_state_t;

   div_state_t st_r;
   div_state_t st_nxt;

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      st_nxt = st_r;
      if (hold)
      begin
         // Held in reset, output parked low
         st_nxt.count     = '0;
         st_nxt.out       = 1'b0;
         st_nxt.ratioHeld = ratio;
      end
      else
      begin
         if (st_r.count + W'(1) >= st_r.ratioHeld)
         begin
            // Ratio sampled at wrap and while held, so the period never tears
            st_nxt.count     = '0;
            st_nxt.ratioHeld = ratio;
         end
         else
         begin
            st_nxt.count = st_r.count + W'(1);
         end
         // High for the first half of each period
         st_nxt.out = (st_nxt.count < (st_nxt.ratioHeld >> 1));
      end
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign divOut = st_r.out;

endmodule : ratio_divider

// [rtl/synth_divider_config_port.sv]
// Configuration logic of a frequency synthesizer: parallel and serial
// loading of the feedback and output dividers, test output select.
// Assumes all pins are synchronous to clock; clock stands for the VCO.
//
// Overview of operation
// - Strobe low passes parallel pins straight through
// - Strobe rise latches pins until fall or serial load
// - Tied pins become the power-up divider setting
// - Parallel mode drives test output low
// - Feedback divider divides VCO by programmed value
// - Output divider divides VCO, 50% duty
// - Strobe high, load low: shift data on rise
// - Load rise transfers shift register into dividers
// - Load fall holds divider values until next load
// - Load held high passes data each serialClock rise
// - Serial frame sets dividers and test-select bits
// - Test select picks low, data, feedback, output
// - Test output active only in serial mode
// - Master reset clears dividers, keeps loaded values
`timescale 1ns/1ns
module synth_divider_config_port
   import synth_cfg_pkg::*;
(
   input  wire logic               clock,
   input  wire logic               nrst,
   input  wire logic               parallelLoadStrobeN,
   input  wire logic [FB_W-1:0]    fbDivIn,
   input  wire logic [OD_W-1:0]    outDivIn,
   input  wire logic               serialClock,
   input  wire logic               serialData,
   input  wire logic               serialLoad,
   input  wire logic               masterResetIn,
   output logic                    foutTrue,
   output logic                    foutComp,
   output logic                    fbDivOut,
   output logic                    testOut,
   output logic                    serialMode,
   output logic [FB_W-1:0]         fbDivValue,
   output logic [OD_W-1:0]         outDivValue,
   output logic [TS_W-1:0]         testSelValue
);

   typedef struct packed {
      logic [FB_W-1:0]    fbDiv;
      logic [OD_W-1:0]    outDiv;
      logic [TS_W-1:0]    testSel;
      logic [FRAME_W-1:0] shiftReg;
      logic               loadPrev;
      logic               sclkPrev;
      logic               serMode;
      logic               test;
      logic               foutT;
      logic               foutC;
   } cfg_state_t;

   cfg_state_t st_r;
   cfg_state_t st_nxt;

   logic                fbDivRaw;
   logic                outDivRaw;
   logic                sclkRise;
   logic                loadRise;
   logic [FRAME_W-1:0]  shifted;
   logic [FRAME_W-1:0]  frame;

   ////////////////////////////////////////////////////////////////////////////
   // Dividers; clock stands in for the VCO
   ratio_divider #(.W(FB_W)) fbDivider
   (
      .clock  (clock),
      .nrst   (nrst),
      .hold   (masterResetIn),
      .ratio  (st_r.fbDiv),
      .divOut (fbDivRaw)
   );

   // Output divider ratio comes from the code table, not the raw code
   ratio_divider #(.W(RATIO_W)) outDivider
   (
      .clock  (clock),
      .nrst   (nrst),
      .hold   (masterResetIn),
      .ratio  (odRatio(st_r.outDiv)),
      .divOut (outDivRaw)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Frame fields, shared by the load edge path and the live path
   function automatic logic [FB_W-1:0] frameFb(input logic [FRAME_W-1:0] frm);
      frameFb = frm[FRM_FB_LSB +: FB_W];
   endfunction : frameFb

   function automatic logic [OD_W-1:0] frameOd(input logic [FRAME_W-1:0] frm);
      frameOd = frm[FRM_OD_LSB +: OD_W];
   endfunction : frameOd

   function automatic logic [TS_W-1:0] frameTs(input logic [FRAME_W-1:0] frm);
      frameTs = frm[FRM_TS_LSB +: TS_W];
   endfunction : frameTs

   // Test output source; dividers feed it registered, so the pin
   // lags them by one cycle, the price of a glitch-free test output
   function automatic logic testSource(input logic [TS_W-1:0] sel,
                                       input logic            sdata,
                                       input logic            fbBit,
                                       input logic            odBit);
      case (sel)
         TS_LOW:    testSource = 1'b0;
         TS_SDATA:  testSource = sdata;
         TS_FBDIV:  testSource = fbBit;
         TS_OUTDIV: testSource = odBit;
         default:   testSource = 1'b0;
      endcase
   endfunction : testSource

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      sclkRise = serialClock && !st_r.sclkPrev;
      loadRise = serialLoad && !st_r.loadPrev;
      // First bit shifted ends at the top of the frame
      shifted  = {st_r.shiftReg[FRAME_W-2:0], serialData};
      // A load edge together with a shift edge takes the new frame
      frame    = sclkRise ? shifted : st_r.shiftReg;
      st_nxt   = st_r;
      st_nxt.loadPrev   = serialLoad;
      st_nxt.sclkPrev   = serialClock;

      if (!parallelLoadStrobeN)
      begin
         // Transparent; tied pins thus set the power-up state
         st_nxt.fbDiv   = fbDivIn;
         st_nxt.outDiv  = outDivIn;
         st_nxt.serMode = 1'b0;
      end
      else
      begin
         // Strobe high: the value taken last cycle stays latched
         if (sclkRise)
         begin
            st_nxt.shiftReg = shifted;
         end
         if (loadRise)
         begin
            // Load rise: the whole frame moves in one cycle
            st_nxt.fbDiv   = frameFb(frame);
            st_nxt.outDiv  = frameOd(frame);
            st_nxt.testSel = frameTs(frame);
            st_nxt.serMode = 1'b1;
         end
         else if (serialLoad && sclkRise)
         begin
            st_nxt.fbDiv   = frameFb(shifted);
            st_nxt.outDiv  = frameOd(shifted);
            st_nxt.testSel = frameTs(shifted);
            st_nxt.serMode = 1'b1;
         end
         // Load fall needs nothing: values simply stay held
      end

      // Test output source, low outside serial mode
      if (!st_nxt.serMode)
      begin
         st_nxt.test = 1'b0;
      end
      else
      begin
         st_nxt.test = testSource(st_nxt.testSel, serialData, fbDivRaw, outDivRaw);
      end

      if (masterResetIn)
      begin
         // Master reset forces true low and complement high
         st_nxt.foutT = 1'b0;
         st_nxt.foutC = 1'b1;
      end
      else
      begin
         // Complement is the registered inverse, never a second divider
         st_nxt.foutT = outDivRaw;
         st_nxt.foutC = !outDivRaw;
      end
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         // Held configuration starts at its chosen power-up values
         st_r          <= '0;
         st_r.fbDiv    <= FB_RST;
         st_r.outDiv   <= OD_RST;
         st_r.testSel  <= TS_RST;
         st_r.foutC    <= 1'b1;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign foutTrue     = st_r.foutT;
   assign foutComp     = st_r.foutC;
   assign fbDivOut     = fbDivRaw;
   assign testOut      = st_r.test;
   assign serialMode   = st_r.serMode;
   assign fbDivValue   = st_r.fbDiv;
   assign outDivValue  = st_r.outDiv;
   assign testSelValue = st_r.testSel;

endmodule : synth_divider_config_port

// [testbench/synth_cfg_properties.sv]
// Checker for the configuration port, seeing only its top ports.
// Assumes one clock domain; bound to every port instance below.
`timescale 1ns/1ns
module synth_cfg_properties
   import synth_cfg_pkg::*;
(
   input wire logic            clock,
   input wire logic            nrst,
   input wire logic            parallelLoadStrobeN,
   input wire logic [FB_W-1:0] fbDivIn,
   input wire logic [OD_W-1:0] outDivIn,
   input wire logic            serialData,
   input wire logic            serialLoad,
   input wire logic            masterResetIn,
   input wire logic            foutTrue,
   input wire logic            foutComp,
   input wire logic            fbDivOut,
   input wire logic            testOut,
   input wire logic            serialMode,
   input wire logic [FB_W-1:0] fbDivValue,
   input wire logic [OD_W-1:0] outDivValue,
   input wire logic [TS_W-1:0] testSelValue
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   a_par_pass: assert property
      (!parallelLoadStrobeN |=> fbDivValue == $past(fbDivIn) && outDivValue == $past(outDivIn))
      else $error("pins not passed through");
   a_par_hold: assert property
      ($rose(parallelLoadStrobeN) && !serialLoad |=> $stable(fbDivValue))
      else $error("latched value moved");
   a_par_test_low: assert property
      (!parallelLoadStrobeN ##1 !parallelLoadStrobeN |=> !testOut && !serialMode)
      else $error("test output active in parallel mode");
   a_load_xfer: assert property
      (parallelLoadStrobeN && $rose(serialLoad) |=> serialMode)
      else $error("load rise not taken");
   a_sel_low: assert property
      (testSelValue == TS_LOW |-> !testOut)
      else $error("test output not low");
   a_sel_data: assert property
      (serialMode && testSelValue == TS_SDATA |-> testOut == $past(serialData))
      else $error("test output not serial data");
   a_sel_fb: assert property
      (serialMode && testSelValue == TS_FBDIV |-> testOut == $past(fbDivOut))
      else $error("test output not feedback divider");
   a_mr_outputs: assert property
      (masterResetIn ##1 masterResetIn |-> !foutTrue && foutComp)
      else $error("outputs not forced by master reset");
   a_mr_keeps: assert property
      (masterResetIn && parallelLoadStrobeN && !serialLoad && !$past(serialLoad)
       |=> $stable(testSelValue) && $stable(fbDivValue))
      else $error("master reset changed loaded values");
endmodule : synth_cfg_properties
////////////////////////////////////////////////////////////////////////////////
bind synth_divider_config_port synth_cfg_properties chk (.*);

// [testbench/cfg_host_model.sv]
// Host model driving the serial pins of the configuration port.
// Assumes the bench calls send; idle pins rest low like pulldowns.
`timescale 1ns/1ns
module cfg_host_model
(
   input  wire logic clock,
   output logic      serialClock,
   output logic      serialData,
   output logic      serialLoad
);
   initial {serialClock, serialData, serialLoad} = 3'h0;
   // Hold sets how many cycles each level stands, slow or prompt
   task automatic send(input logic [12:0] frm, input int hold);
      @(posedge clock);
      for (int i = 12; i >= 0; i--)
      begin
         #1 serialData = frm[i];
         serialClock = 1'b0;
         repeat (hold) @(posedge clock);
         #1 serialClock = 1'b1;
         repeat (hold) @(posedge clock);
      end
      #1 serialClock = 1'b0;
      serialData = 1'b0;
      repeat (hold) @(posedge clock);
      #1 serialLoad = 1'b1;
      repeat (2) @(posedge clock);
      #1 serialLoad = 1'b0;
   endtask : send
   // Load held high: every serialClock rise passes the frame straight through
   task automatic stream(input logic [12:0] frm);
      @(posedge clock);
      #1 serialLoad = 1'b1;
      for (int i = 12; i >= 0; i--)
      begin
         @(posedge clock);
         #1 serialData = frm[i];
         serialClock = 1'b0;
         @(posedge clock);
         #1 serialClock = 1'b1;
      end
      @(posedge clock);
      #1 serialClock = 1'b0;
      serialData = 1'b0;
      serialLoad = 1'b0;
   endtask : stream
endmodule : cfg_host_model

// [testbench/test_synth_divider_config_port.sv]
// Bench for the configuration port: parallel, serial, test output.
// Assumes the host model drives the serial pins.
`timescale 1ns/1ns
module test_synth_divider_config_port;
   import synth_cfg_pkg::*;
   logic clock = 0, nrst = 0, parallelLoadStrobeN = 0, masterResetIn = 0;
   logic [FB_W-1:0] fbDivIn = 9'h01b, fbDivValue;
   logic [OD_W-1:0] outDivIn = 2'h1, outDivValue;
   logic [TS_W-1:0] testSelValue;
   logic serialClock, serialData, serialLoad, foutTrue, foutComp, fbDivOut, testOut, serialMode;
   int num_errors = 0, checks = 0, cycles = 0;
   synth_divider_config_port DUT (.*);
   cfg_host_model host (.clock, .serialClock, .serialData, .serialLoad);
   initial forever #5 clock = ~clock;
   ////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      if (num_errors == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_of_test
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         num_errors++;
         end_of_test();
      end
   end
   task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
      checks++;
      if (exp !== got)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic parallel_pass();
      chk("fbDivValue", 9'h01b, fbDivValue);
      for (int v = 25; v <= 31; v++)
      begin
         @(posedge clock);
         #1 fbDivIn = 9'(v);
         outDivIn = 2'(v);
         @(posedge clock);
         #1 chk("fbDivValue", 9'(v), fbDivValue);
         chk("outDivValue", 9'(v % 4), 9'(outDivValue));
         chk("testOut", 9'h000, 9'(testOut));
      end
      @(posedge clock);
      #1 parallelLoadStrobeN = 1'b1;
      fbDivIn = 9'h1ff;
      repeat (3) @(posedge clock);
      #1 chk("fbDivValue", 9'h01f, fbDivValue);
   endtask : parallel_pass
   // Count over 432 cycles, a whole number of periods for 27 and 16
   task automatic serial_frames();
      int hi;
      for (int ts = 0; ts < 4; ts++)
      begin
         host.send({2'(ts), 2'(ts), 9'(25 + ts)}, ts % 2 + 1);
         chk("fbDivValue", 9'(25 + ts), fbDivValue);
         chk("outDivValue", 9'(ts), 9'(outDivValue));
         chk("testSelValue", 9'(ts), 9'(testSelValue));
         chk("serialMode", 9'h001, 9'(serialMode));
         repeat (64) @(posedge clock);
         hi = 0;
         repeat (432)
         begin
            @(posedge clock);
            hi += int'(testOut);
         end
         chk("testOut high", 9'(ts == 2 ? 208 : ts == 3 ? 216 : 0), 9'(hi));
      end
   endtask : serial_frames
   task automatic master_reset();
      #1 masterResetIn = 1'b1;
      repeat (3) @(posedge clock);
      #1 chk("foutTrue", 9'h000, 9'(foutTrue));
      chk("foutComp", 9'h001, 9'(foutComp));
      chk("testSelValue", 9'h003, 9'(testSelValue));
      masterResetIn = 1'b0;
      parallelLoadStrobeN = 1'b0;
      repeat (3) @(posedge clock);
      #1 chk("serialMode", 9'h000, 9'(serialMode));
      chk("testOut", 9'h000, 9'(testOut));
   endtask : master_reset
   task automatic serial_live();
      parallelLoadStrobeN = 1'b1;
      host.stream({2'h2, 2'h1, 9'h01e});
      chk("fbDivValue", 9'h01e, fbDivValue);
      chk("outDivValue", 9'h001, 9'(outDivValue));
      chk("testSelValue", 9'h002, 9'(testSelValue));
      chk("serialMode", 9'h001, 9'(serialMode));
      repeat (2) @(posedge clock);
      #1 chk("fbDivValue", 9'h01e, fbDivValue);
   endtask : serial_live
   initial
   begin
      repeat (4) @(posedge clock);
      #1 nrst = 1'b1;
      repeat (3) @(posedge clock);
      #1 parallel_pass();
      serial_frames();
      master_reset();
      serial_live();
      end_of_test();
   end
endmodule : test_synth_divider_config_port
